// ===== core/dps_pkg.sv
// Package: command encodings, bank states and timing for DDR power control
package dps_pkg;
  // Command encodings as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_BURST_STOP = 3'h6;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_ACTIVE = 3'h3;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_MODE_SET = 3'h0;
  // Power-down exit interval in ns, and in clock cycles (rounded up)
  localparam int CLK_PERIOD_NS = 100;
  localparam int POWER_DOWN_EXIT_INTERVAL_NS = 100;
  localparam int PDEX_CYCLES_RAW =
    (POWER_DOWN_EXIT_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PDEX_CYCLES = (PDEX_CYCLES_RAW < 1) ? 1 : PDEX_CYCLES_RAW;
  // Busy time of refresh and mode register set, in cycles
  localparam int REFRESH_CYCLES = 8;
  localparam int MODE_SET_CYCLES = 2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // Bank state codes held per bank
  localparam logic [1:0] BANK_IDLE = 2'h0;
  localparam logic [1:0] BANK_ACTIVE = 2'h1;
  localparam logic [1:0] BANK_PRECHARGING = 2'h2;
  // Device power state, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ACTIVE = 6'h02,
    ST_REFRESHING = 6'h04,
    ST_MODE_SETTING = 6'h08,
    ST_SELF_REFRESH = 6'h10,
    ST_POWER_DOWN = 6'h20
  } dps_state_t;
endpackage

// ===== core/dps_bank.sv
// One bank's idle/active/precharging state tracker
`timescale 1ns/1ns
`default_nettype none
module dps_bank
  import dps_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Per-bank command strobes
  input wire logic activate,
  input wire logic precharge,
  input wire logic precharge_done,
  // State
  output logic [1:0] bank_state
);
  logic [1:0] state_q;
  logic [1:0] state_d;

  always_comb begin
    state_d = state_q;
    if (activate && state_q == BANK_IDLE) begin
      state_d = BANK_ACTIVE;
    end else if (precharge) begin
      // Idle or already precharging banks ignore a precharge
      if (state_q == BANK_ACTIVE) begin
        state_d = BANK_PRECHARGING;
      end
    end else if (precharge_done && state_q == BANK_PRECHARGING) begin
      state_d = BANK_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= BANK_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign bank_state = state_q;
endmodule // dps_bank
`default_nettype wire

// ===== core/dps_ctrl.sv
// DDR SDRAM power-state and command-legality control
// Function
// - During refresh or mode register set every command except no-operation is illegal.
// - Self-refresh holds while clock enable stays low; rise exits it.
// - Self-refresh exit cycle allows only deselect or no-operation.
// - Power-down holds while clock enable low; rise exits, idle after interval.
// - Entry needs all banks idle; refresh enters self-refresh, nop power-down.
// - Banks idle with previous clock enable low uses power-down handling.
// - Banks idle, clock enable high twice: normal command decoding.
// - Other states with clock enable high twice: normal decoding.
// - Illegal judgement of bank commands applies only to the addressed bank's state.
// - Precharge to idle or precharging bank acts as no-operation.
// - Refresh and mode register set illegal when any bank is not idle.
`timescale 1ns/1ns
`default_nettype none
module dps_ctrl
  import dps_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int BA_W = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Memory command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] bank_addr,
  input wire logic all_banks,
  // Status
  output logic illegal_cmd,
  output logic self_refresh,
  output logic power_down,
  output logic busy,
  output logic [BANKS-1:0] bank_active,
  output logic cmd_accepted
);
  dps_state_t state_q;
  dps_state_t state_d;
  logic cke_q;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic illegal_q;
  logic illegal_d;
  logic accepted_q;
  logic accepted_d;
  logic [2:0] cmd;
  logic sel;
  logic all_idle;
  logic bank_busy;
  logic [BANKS-1:0] act_v;
  logic [BANKS-1:0] pre_v;
  logic [BANKS-1:0] idle_v;
  logic [1:0] bank_st [BANKS];
  logic pre_done;
  logic cke_rise;
  logic cke_fall;
  logic cke_held;
  logic cnt_last;

  assign cmd = {ras_n, cas_n, we_n};
  assign sel = !cs_n;
  assign all_idle = &idle_v;
  // The addressed bank alone decides legality of bank commands
  assign bank_busy = bank_st[bank_addr] != BANK_IDLE;
  assign pre_done = (state_q == ST_ACTIVE) && !(sel && cmd == CMD_PRECHARGE);
  // Previous against current clock enable picks the handling path
  assign cke_rise = !cke_q && cke;
  assign cke_fall = cke_q && !cke;
  assign cke_held = cke_q && cke;
  // Zero also ends a busy phase, so a stale count can never hang it
  assign cnt_last = (cnt_q == CNT_ONE) || (cnt_q == CNT_ZERO);

  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      dps_bank u_bank (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .activate(act_v[g]),
        .precharge(pre_v[g]),
        .precharge_done(pre_done),
        .bank_state(bank_st[g])
      );
      assign idle_v[g] = bank_st[g] == BANK_IDLE;
      assign bank_active[g] = bank_st[g] == BANK_ACTIVE;
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO;
    illegal_d = 1'b0;
    accepted_d = 1'b0;
    act_v = '0;
    pre_v = '0;
    case (state_q)
      ST_REFRESHING, ST_MODE_SETTING: begin
        if (sel && cmd != CMD_NOP) begin
          illegal_d = 1'b1;
        end
        if (cnt_last) begin
          state_d = ST_IDLE;
        end
      end
      ST_SELF_REFRESH: begin
        if (cke_rise) begin
          // Exit allowed only with deselect or nop
          if (sel && cmd != CMD_NOP) begin
            illegal_d = 1'b1;
          end
          // Clock-enable rise leaves self-refresh
          state_d = ST_POWER_DOWN;
          cnt_d = 4'(PDEX_CYCLES);
        end
      end
      ST_POWER_DOWN: begin
        // Stays until clock enable rises, then idles after exit interval
        if (cke_held) begin
          if (cnt_last) begin
            state_d = ST_IDLE;
          end
        end else if (cke_rise) begin
          cnt_d = 4'(PDEX_CYCLES);
        end
      end
      default: begin
        // Clock enable history picks the handling path
        if (all_idle && !cke_q) begin
          state_d = ST_POWER_DOWN;
          cnt_d = 4'(PDEX_CYCLES);
        end else if (cke_fall) begin
          // Falling clock enable: entry only with all banks idle
          if (!all_idle) begin
            illegal_d = 1'b1;
          end else if (!sel || cmd == CMD_NOP) begin
            state_d = ST_POWER_DOWN;
          end else if (cmd == CMD_REFRESH) begin
            state_d = ST_SELF_REFRESH;
          end else begin
            illegal_d = 1'b1;
          end
        end else if (cke_held && sel) begin
          // Normal decoding, idle or active banks alike
          case (cmd)
            CMD_REFRESH, CMD_MODE_SET: begin
              if (!all_idle) begin
                illegal_d = 1'b1;
              end else begin
                accepted_d = 1'b1;
                state_d = (cmd == CMD_REFRESH) ? ST_REFRESHING
                                               : ST_MODE_SETTING;
                cnt_d = (cmd == CMD_REFRESH) ? 4'(REFRESH_CYCLES)
                                             : 4'(MODE_SET_CYCLES);
              end
            end
            CMD_ACTIVE: begin
              if (bank_busy) begin
                illegal_d = 1'b1;
              end else begin
                accepted_d = 1'b1;
                act_v[bank_addr] = 1'b1;
              end
            end
            CMD_PRECHARGE: begin
              // Harmless to idle banks, so always accepted
              accepted_d = 1'b1;
              if (all_banks) begin
                pre_v = '1;
              end else begin
                pre_v[bank_addr] = 1'b1;
              end
            end
            CMD_READ, CMD_WRITE, CMD_BURST_STOP: begin
              if (!bank_busy || bank_st[bank_addr] != BANK_ACTIVE) begin
                illegal_d = 1'b1;
              end else begin
                accepted_d = 1'b1;
              end
            end
            default: begin
              accepted_d = 1'b0;
            end
          endcase
        end
        if (state_d == ST_IDLE || state_d == ST_ACTIVE) begin
          state_d = all_idle && act_v == '0 ? ST_IDLE : ST_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cke_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      illegal_q <= 1'b0;
      accepted_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cke_q <= cke;
      cnt_q <= cnt_d;
      illegal_q <= illegal_d;
      accepted_q <= accepted_d;
    end
  end

  // Reset leaves cke_q low, so the first cycles pass via power-down handling
  assign illegal_cmd = illegal_q;
  assign cmd_accepted = accepted_q;
  assign self_refresh = state_q == ST_SELF_REFRESH;
  assign power_down = state_q == ST_POWER_DOWN;
  assign busy = (state_q == ST_REFRESHING) || (state_q == ST_MODE_SETTING);
endmodule // dps_ctrl
`default_nettype wire

// ===== tb/dps_monitor.sv
// Checker of power states and command legality at the control ports
`timescale 1ns/1ns
`default_nettype none
module dps_monitor
  import dps_pkg::*;
#(parameter int BANKS = 4, parameter int BA_W = 2) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] bank_addr,
  input wire logic all_banks,
  // Status
  input wire logic illegal_cmd,
  input wire logic self_refresh,
  input wire logic power_down,
  input wire logic busy,
  input wire logic [BANKS-1:0] bank_active,
  input wire logic cmd_accepted
);
  logic [2:0] cmd;
  logic cke_q;
  logic rdy;
  logic sel;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  assign cmd = {ras_n, cas_n, we_n};
  assign sel = !cs_n && cmd != CMD_NOP;
  assign rdy = !busy && !self_refresh && !power_down && cke_q;
  // Resets low like the core, so the first cycle counts as a wake-up
  always_ff @(posedge ref_clk) cke_q <= resetn && cke;
  busy_refuse_a: assert property (busy && cke && sel |=> illegal_cmd)
    else $error("command taken while busy");
  sr_hold_a: assert property (self_refresh && !cke |=> self_refresh)
    else $error("self-refresh left with clock enable low");
  sr_exit_a: assert property (self_refresh && cke && sel
    |=> illegal_cmd)
    else $error("bad self-refresh exit not flagged");
  pd_exit_a: assert property (power_down && cke
    |-> ##[1:3] !power_down)
    else $error("power-down not left");
  sr_entry_a: assert property (rdy && !cke && bank_active == '0 && !cs_n &&
    cmd == CMD_REFRESH |=> self_refresh)
    else $error("self-refresh not entered");
  pd_entry_a: assert property (rdy && !cke && bank_active == '0 && !sel
    |=> power_down && !self_refresh)
    else $error("power-down not entered");
  ref_banks_a: assert property (rdy && cke && bank_active != '0 && !cs_n &&
    cmd == CMD_REFRESH |=> illegal_cmd)
    else $error("refresh with open bank not flagged");
  pre_nop_a: assert property (rdy && cke && !cs_n && cmd == CMD_PRECHARGE
    |=> !illegal_cmd)
    else $error("precharge flagged");
  act_open_a: assert property (rdy && cke && !cs_n &&
    cmd == CMD_ACTIVE && !bank_active[bank_addr]
    |=> bank_active[$past(bank_addr)] && cmd_accepted)
    else $error("activate not taken");
  cover property ($rose(self_refresh));
  cover property ($rose(power_down));
  cover property ($rose(busy));
endmodule // dps_monitor
bind dps_ctrl dps_monitor #(.BANKS(BANKS), .BA_W(BA_W)) u_mon (.ref_clk,
  .resetn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .all_banks,
  .illegal_cmd, .self_refresh, .power_down, .busy, .bank_active, .cmd_accepted);
`default_nettype wire

// ===== tb/dps_mc_model.sv
// Memory controller model driving the command pins
`timescale 1ns/1ns
`default_nettype none
module dps_mc_model
  import dps_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank_addr,
  output logic all_banks
);
  initial {cke, cs_n, ras_n, cas_n, we_n, bank_addr, all_banks} = 8'hff;
  // One command per edge, 10 ns after it; NOP means deselect, and the
  // unselected lines toggle so no stale value looks valid
  task automatic send(input logic k, input logic [2:0] c,
    input logic [1:0] b, input logic a);
    cke = k;
    cs_n = (c == CMD_NOP);
    {ras_n, cas_n, we_n} = cs_n ? ~{ras_n, cas_n, we_n} : c;
    bank_addr = b;
    all_banks = a;
    @(posedge ref_clk);
    #10;
  endtask
endmodule // dps_mc_model
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench: power-state and command legality scenarios
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top
  import dps_pkg::*;
;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic cke, cs_n, ras_n, cas_n, we_n, all_banks;
  logic [1:0] bank_addr;
  logic illegal_cmd, self_refresh, power_down, busy, cmd_accepted;
  logic [3:0] bank_active;
  int bad_count = 0;
  int checks_done = 0;
  initial forever #50 ref_clk = ~ref_clk;
  dps_mc_model mc (.ref_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr,
    .all_banks);
  dps_ctrl dut (.ref_clk, .resetn, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .bank_addr, .all_banks, .illegal_cmd, .self_refresh, .power_down, .busy,
    .bank_active, .cmd_accepted);
  task automatic nop(input logic k);
    mc.send(k, CMD_NOP, 2'h0, 1'h0);
  endtask
  // Bounded wait; deselect only, so no command meets the exit setup time
  task automatic settle();
    for (int i = 0; i < 20 && (busy | power_down | self_refresh) !== 1'h0;
      i++) nop(1'h1);
    `CHK("settle", 1'h0, busy | power_down | self_refresh)
  endtask
  task automatic t_busy();
    mc.send(1'h1, CMD_REFRESH, 2'h0, 1'h0);
    `CHK("refresh", 2'h3, {busy, cmd_accepted})
    for (int c = 1; c < 7; c++) begin
      mc.send(1'h1, 3'(c), 2'h1, 1'h0);
      `CHK("cmd in refresh", 1'h1, illegal_cmd)
    end
    settle();
    mc.send(1'h1, CMD_MODE_SET, 2'h0, 1'h0);
    `CHK("mode set", 1'h1, busy)
    mc.send(1'h1, CMD_MODE_SET, 2'h0, 1'h0);
    `CHK("cmd in mode set", 1'h1, illegal_cmd)
    settle();
    $display("t_busy done");
  endtask
  task automatic t_bank();
    mc.send(1'h1, CMD_ACTIVE, 2'h1, 1'h0);
    `CHK("act b1", 4'h2, bank_active)
    mc.send(1'h1, CMD_ACTIVE, 2'h1, 1'h0);
    `CHK("act b1 again", 1'h1, illegal_cmd)
    mc.send(1'h1, CMD_ACTIVE, 2'h2, 1'h0);
    `CHK("act b2", 5'h06, {illegal_cmd, bank_active})
    mc.send(1'h1, CMD_REFRESH, 2'h0, 1'h0);
    `CHK("refresh open", 1'h1, illegal_cmd)
    mc.send(1'h1, CMD_PRECHARGE, 2'h0, 1'h0);
    `CHK("pre idle", 5'h06, {illegal_cmd, bank_active})
    mc.send(1'h1, CMD_PRECHARGE, 2'h0, 1'h1);
    `CHK("pre all", 4'h0, bank_active)
    nop(1'h1);
    settle();
    $display("t_bank done");
  endtask
  task automatic t_power();
    mc.send(1'h0, CMD_REFRESH, 2'h0, 1'h0);
    `CHK("sr entry", 1'h1, self_refresh)
    repeat (3) mc.send(1'h0, CMD_READ, 2'h0, 1'h0);
    `CHK("sr hold", 2'h2, {self_refresh, illegal_cmd})
    mc.send(1'h1, CMD_READ, 2'h0, 1'h0);
    `CHK("sr bad exit", 1'h1, illegal_cmd)
    settle();
    mc.send(1'h0, CMD_REFRESH, 2'h0, 1'h0);
    nop(1'h1);
    `CHK("sr exit", 2'h1, {self_refresh, power_down})
    settle();
    nop(1'h0);
    `CHK("pd entry", 2'h1, {self_refresh, power_down})
    repeat (3) mc.send(1'h0, CMD_WRITE, 2'h0, 1'h0);
    `CHK("pd hold", 2'h1, {illegal_cmd, power_down})
    nop(1'h1);
    `CHK("pd exit wait", 1'h1, power_down)
    settle();
    mc.send(1'h0, CMD_WRITE, 2'h0, 1'h0);
    `CHK("bad entry", 1'h1, illegal_cmd)
    nop(1'h1);
    settle();
    $display("t_power done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #10 resetn = 1'h1;
    repeat (2) nop(1'h1);
    settle();
    t_busy();
    t_bank();
    t_power();
    complete_run();
  end
  // Tests take about 45 cycles; allow a wide margin
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
